// ### design/dma_arb_pkg.sv
// constants and carrier types for the dma channel arbiter
package dma_arb_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int NUM_REQ = 16;
    localparam int NUM_CHAN = 8;
    localparam int CNT_W = 16;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRIO = 8'h04;
    localparam logic [7:0] OFF_MAP_LO = 8'h08;
    localparam logic [7:0] OFF_MAP_HI = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CNT_BASE = 8'h20;

    // ********************************
    // field positions
    // ********************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FAIR_BIT = 1;
    localparam int PRIO_CH0_LSB = 0;
    localparam int PRIO_CH4_LSB = 8;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_X16_BIT = 5;
    localparam int ST_CHAN_LSB = 8;
    localparam int ST_SERVED_LSB = 16;

    // ********************************
    // reset values
    // ********************************
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [3:0] PRIO_CH0_RST = 4'h0;
    localparam logic [3:0] PRIO_CH4_RST = 4'h4;
    localparam logic [63:0] MAP_RST = 64'h7654321076543210;
    localparam logic [15:0] CNT_RST = 16'h0001;

    // ********************************
    // carrier for the eight arbitration lines
    // ********************************
    typedef struct packed {
        logic [3:0] level;
        logic gnt;
        logic burst;
        logic tc;
        logic busy;
    } arb_lines_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARB = 3'b010,
        ST_GRANT = 3'b100
    } arb_state_t;

endpackage

// ### design/dma_channel_arbiter.sv
// central arbiter: sixteen requesters share eight dma channels, apb registers
// Function
// - sixteen requesters compete for eight dma channels
// - highest priority level wins simultaneous requests
// - fairness: served requester waits for all others
// - fixed channel levels, channels 0 and 4 programmable
// - each channel moves eight or sixteen bit data
// - eight arbitration lines, single and burst transfers
// - terminal count line pulsed to dma slave
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_arbiter #(
    parameter int NUM_REQ = dma_arb_pkg::NUM_REQ,
    parameter int NUM_CHAN = dma_arb_pkg::NUM_CHAN
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_REQ-1:0] i_req,
    input wire logic [NUM_REQ-1:0] i_burst,
    input wire logic [NUM_REQ-1:0] i_size16,
    input wire logic i_xfer_done,
    output logic [NUM_REQ-1:0] o_gnt,
    output logic o_xfer16,
    output dma_arb_pkg::arb_lines_t o_lines
);

    localparam int CW = dma_arb_pkg::CNT_W;

    // ********************************
    // state
    // ********************************
    dma_arb_pkg::arb_state_t state_q;
    dma_arb_pkg::arb_state_t state_d;
    logic [1:0] ctrl_q;
    logic [3:0] prio0_q;
    logic [3:0] prio4_q;
    logic [63:0] map_q;
    logic [CW-1:0] cnt_q [NUM_CHAN];
    logic [NUM_REQ-1:0] served_q;
    logic [3:0] win_q;
    logic burst_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    // ********************************
    // helpers
    // ********************************
    function automatic logic [2:0] chan_of(input logic [63:0] m, input logic [3:0] r);
        chan_of = m[{r, 2'b00} +: 3];
    endfunction

    function automatic logic [3:0] level_of(input logic [2:0] ch, input logic [3:0] p0,
                                            input logic [3:0] p4);
        if (ch == 3'h0)
        begin
            level_of = p0;
        end
        else if (ch == 3'h4)
        begin
            level_of = p4;
        end
        else
        begin
            level_of = {1'b0, ch};
        end
    endfunction

    function automatic logic cnt_hit(input logic [7:0] a, input logic [2:0] ch);
        cnt_hit = (a == dma_arb_pkg::OFF_CNT_BASE + {3'h0, ch, 2'b00});
    endfunction

    // ********************************
    // apb decode
    // ********************************
    wire logic setup = i_psel && !i_penable;
    wire logic wr_acc = i_psel && i_penable && i_pwrite;
    wire logic is_ctrl = i_paddr == dma_arb_pkg::OFF_CTRL;
    wire logic is_prio = i_paddr == dma_arb_pkg::OFF_PRIO;
    wire logic is_mlo = i_paddr == dma_arb_pkg::OFF_MAP_LO;
    wire logic is_mhi = i_paddr == dma_arb_pkg::OFF_MAP_HI;
    wire logic is_stat = i_paddr == dma_arb_pkg::OFF_STATUS;
    logic [NUM_CHAN-1:0] is_cnt;
    wire logic mapped = is_ctrl || is_prio || is_mlo || is_mhi || is_stat || (|is_cnt);

    // ********************************
    // arbitration
    // ********************************
    wire logic en = ctrl_q[dma_arb_pkg::CTRL_EN_BIT];
    wire logic fair = ctrl_q[dma_arb_pkg::CTRL_FAIR_BIT];
    wire logic [NUM_REQ-1:0] pend = en ? i_req : '0;
    wire logic [NUM_REQ-1:0] unserved = pend & ~served_q;
    wire logic [NUM_REQ-1:0] elig = (fair && |unserved) ? unserved : pend;
    logic [3:0] win_idx;
    logic [3:0] win_lvl;
    logic win_found;

    always_comb
    begin
        win_found = 1'b0;
        win_idx = 4'h0;
        win_lvl = 4'hf;
        for (int i = 0; i < NUM_REQ; i++)
        begin
            if (elig[i] && (!win_found ||
                level_of(chan_of(map_q, 4'(i)), prio0_q, prio4_q) < win_lvl))
            begin
                win_found = 1'b1;
                win_idx = 4'(i);
                win_lvl = level_of(chan_of(map_q, 4'(i)), prio0_q, prio4_q);
            end
        end
    end

    wire logic [2:0] gch = chan_of(map_q, win_q);
    wire logic [NUM_REQ-1:0] win_oh = NUM_REQ'(1) << win_q;
    wire logic tc_hit = (state_q == dma_arb_pkg::ST_GRANT) && i_xfer_done
                        && (cnt_q[gch] <= CW'(1));
    wire logic rel = !i_req[win_q] || tc_hit || (i_xfer_done && !burst_q);
    wire logic [NUM_REQ-1:0] left = unserved & ~win_oh;

    // ********************************
    // state machine
    // ********************************
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            dma_arb_pkg::ST_IDLE:
            begin
                if (win_found)
                begin
                    state_d = dma_arb_pkg::ST_ARB;
                end
            end
            dma_arb_pkg::ST_ARB:
            begin
                state_d = i_req[win_q] && en ? dma_arb_pkg::ST_GRANT : dma_arb_pkg::ST_IDLE;
            end
            dma_arb_pkg::ST_GRANT:
            begin
                if (rel)
                begin
                    state_d = dma_arb_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_d = dma_arb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= dma_arb_pkg::ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // latch the winner while idle; the arb cycle shows its level on the lines
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            win_q <= 4'h0;
            burst_q <= 1'b0;
        end
        else if (state_q == dma_arb_pkg::ST_IDLE && win_found)
        begin
            win_q <= win_idx;
            burst_q <= i_burst[win_idx];
        end
    end

    // served set: cleared once every other pending requester had its turn
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            served_q <= '0;
        end
        else if (!fair)
        begin
            served_q <= '0;
        end
        else if (state_q == dma_arb_pkg::ST_ARB && state_d == dma_arb_pkg::ST_GRANT)
        begin
            served_q <= (left == '0) ? '0 : (served_q | win_oh);
        end
    end

    // ********************************
    // grant outputs
    // ********************************
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_gnt <= '0;
            o_xfer16 <= 1'b0;
            o_lines <= '0;
        end
        else
        begin
            o_gnt <= (state_d == dma_arb_pkg::ST_GRANT) ? win_oh : '0;
            o_xfer16 <= (state_d == dma_arb_pkg::ST_GRANT) && i_size16[win_q];
            o_lines.level <= (state_d == dma_arb_pkg::ST_IDLE) ? 4'h0
                             : level_of(chan_of(map_q, (state_q == dma_arb_pkg::ST_IDLE)
                             ? win_idx : win_q), prio0_q, prio4_q);
            o_lines.gnt <= state_d == dma_arb_pkg::ST_GRANT;
            o_lines.burst <= (state_d == dma_arb_pkg::ST_GRANT) && burst_q;
            o_lines.tc <= tc_hit;
            o_lines.busy <= state_d != dma_arb_pkg::ST_IDLE;
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_q <= dma_arb_pkg::CTRL_RST;
            prio0_q <= dma_arb_pkg::PRIO_CH0_RST;
            prio4_q <= dma_arb_pkg::PRIO_CH4_RST;
            map_q <= dma_arb_pkg::MAP_RST;
        end
        else if (wr_acc)
        begin
            if (is_ctrl)
            begin
                ctrl_q <= i_pwdata[1:0];
            end
            if (is_prio)
            begin
                prio0_q <= i_pwdata[dma_arb_pkg::PRIO_CH0_LSB +: 4];
                prio4_q <= i_pwdata[dma_arb_pkg::PRIO_CH4_LSB +: 4];
            end
            if (is_mlo)
            begin
                map_q[31:0] <= i_pwdata;
            end
            if (is_mhi)
            begin
                map_q[63:32] <= i_pwdata;
            end
        end
    end

    // per-channel transfer counters; a software write beats the decrement
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++)
        begin : g_cnt
            assign is_cnt[c] = cnt_hit(i_paddr, 3'(c));
            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    cnt_q[c] <= dma_arb_pkg::CNT_RST;
                end
                else if (wr_acc && is_cnt[c])
                begin
                    cnt_q[c] <= i_pwdata[CW-1:0];
                end
                else if (state_q == dma_arb_pkg::ST_GRANT && i_xfer_done && gch == 3'(c)
                         && cnt_q[c] != '0)
                begin
                    cnt_q[c] <= cnt_q[c] - CW'(1);
                end
            end
        end
    endgenerate

    // ********************************
    // read path, sampled in the setup cycle
    // ********************************
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        if (is_ctrl)
        begin
            rd_mux = {30'h0, ctrl_q};
        end
        if (is_prio)
        begin
            rd_mux = {20'h0, prio4_q, 4'h0, prio0_q};
        end
        if (is_mlo)
        begin
            rd_mux = map_q[31:0];
        end
        if (is_mhi)
        begin
            rd_mux = map_q[63:32];
        end
        if (is_stat)
        begin
            rd_mux[3:0] = win_q;
            rd_mux[dma_arb_pkg::ST_BUSY_BIT] = o_lines.busy;
            rd_mux[dma_arb_pkg::ST_X16_BIT] = o_xfer16;
            rd_mux[dma_arb_pkg::ST_CHAN_LSB +: 3] = gch;
            rd_mux[dma_arb_pkg::ST_SERVED_LSB +: 16] = served_q;
        end
        for (int k = 0; k < NUM_CHAN; k++)
        begin
            if (is_cnt[k])
            begin
                rd_mux = {16'h0, cnt_q[k]};
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            prdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= i_pwrite ? 32'h0 : rd_mux;
            slverr_q <= !mapped;
        end
    end

    assign o_pready = i_psel && i_penable;
    assign o_prdata = prdata_q;
    assign o_pslverr = o_pready && slverr_q;

endmodule
`default_nettype wire

// ### testbench/dma_arb_checker.sv
// assertions on the ports of the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
module dma_arb_checker #(
    parameter int NUM_REQ = 16
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [NUM_REQ-1:0] i_req,
    input wire logic [NUM_REQ-1:0] i_burst,
    input wire logic [NUM_REQ-1:0] i_size16,
    input wire logic i_xfer_done,
    input wire logic [NUM_REQ-1:0] o_gnt,
    input wire logic o_xfer16,
    input wire dma_arb_pkg::arb_lines_t o_lines
);
    // ****************
    // grant checks
    // ****************
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    onehot_gnt_a: assert property ($onehot0(o_gnt))
        else $error("grant not one-hot");
    gnt_req_a: assert property ((o_gnt & ~$past(o_gnt) & ~$past(i_req)) == '0)
        else $error("grant without request");
    arb_first_a: assert property ($rose(o_lines.gnt) |-> $past(o_lines.busy))
        else $error("grant without arbitration cycle");
    single_end_a: assert property (
        o_lines.gnt && !o_lines.burst && i_xfer_done |=> !o_lines.gnt)
        else $error("single grant kept");
    drop_end_a: assert property ((o_gnt & ~i_req) != '0 |=> o_gnt == '0)
        else $error("grant kept after drop");
    tc_pulse_a: assert property (o_lines.tc |-> $past(i_xfer_done) ##1 !o_lines.tc)
        else $error("bad terminal count");
    width_a: assert property (o_lines.gnt |-> o_xfer16 == |(o_gnt & i_size16))
        else $error("width wrong");
    burst_mode_a: assert property (o_lines.gnt |-> o_lines.burst == |(o_gnt & i_burst))
        else $error("burst mode wrong");
    gnt_line_a: assert property (o_lines.gnt == (o_gnt != '0))
        else $error("grant line disagrees");
    idle_level_a: assert property (!o_lines.busy |-> o_lines.level == 4'h0)
        else $error("level while idle");
    arb_level_a: assert property (
        o_lines.busy && !o_lines.gnt ##1 o_lines.gnt |-> $stable(o_lines.level))
        else $error("level changed at grant");
endmodule
bind dma_channel_arbiter dma_arb_checker #(.NUM_REQ(NUM_REQ)) chk_i (.i_mclk(i_mclk),
    .i_nrst(i_nrst), .i_req(i_req), .i_burst(i_burst), .i_size16(i_size16),
    .i_xfer_done(i_xfer_done), .o_gnt(o_gnt), .o_xfer16(o_xfer16), .o_lines(o_lines));
`default_nettype wire

// ### testbench/dma_requesters.sv
// model of the requesting adapters
`timescale 1ns/1ps
`default_nettype none
module dma_requesters (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_load,
    input wire logic i_keep,
    input wire logic i_slow,
    input wire logic [15:0] i_want,
    input wire logic [15:0] i_gnt,
    output var logic [15:0] o_req,
    output logic [15:0] o_burst,
    output logic [15:0] o_size16,
    output var logic o_done
);
    logic hold_q;
    logic two_q;
    logic [1:0] wait_q;
    wire logic is_burst = (i_gnt & o_burst) != 16'h0;
    wire logic on = i_gnt != 16'h0;
    wire logic go = on && !hold_q && !o_done && !(i_slow && wait_q != 2'h3);
    assign o_burst = 16'h0004;
    assign o_size16 = 16'h5a3c;
    always_ff @(posedge i_mclk or negedge i_nrst)
        if (!i_nrst)
        begin
            o_req <= 16'h0;
            o_done <= 1'b0;
            hold_q <= 1'b0;
            two_q <= 1'b0;
            wait_q <= 2'h0;
        end
        else
        begin
            o_done <= go;
            wait_q <= (on && !go && !hold_q) ? wait_q + 2'h1 : 2'h0;
            hold_q <= go ? (!is_burst || two_q) : hold_q && on;
            two_q <= go ? (is_burst && !two_q) : two_q && on;
            if (i_load)
                o_req <= i_want;
            else if (go && ((!is_burst && !i_keep) || two_q))
                o_req <= o_req & ~i_gnt;
        end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, load = 1'b0;
    logic keep = 1'b0, slow = 1'b0, fair = 1'b0, prdy, perr, er, xdone, x16;
    logic [7:0] pad = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd, seed = 32'h7aed;
    logic [15:0] want = 16'h0, pend, served = 16'h0, w, req, burst, size16, gnt;
    logic [3:0] p0 = 4'h0, p4 = 4'h4;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h10, 8'h14};
    logic [31:0] rv [7] = '{32'h1, 32'h400, 32'h76543210, 32'h76543210, 32'h1, 32'h0, 32'h0};
    int n_errors = 0, comparisons = 0;
    dma_arb_pkg::arb_lines_t lines;
    dma_channel_arbiter uut (.i_mclk(mclk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pad), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
        .o_pslverr(perr), .i_req(req), .i_burst(burst), .i_size16(size16),
        .i_xfer_done(xdone), .o_gnt(gnt), .o_xfer16(x16), .o_lines(lines));
    dma_requesters far_i (.i_mclk(mclk), .i_nrst(nrst), .i_load(load), .i_keep(keep),
        .i_slow(slow), .i_want(want), .i_gnt(gnt), .o_req(req), .o_burst(burst),
        .o_size16(size16), .o_done(xdone));
    initial
        forever #10 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo(input int t);
        if (t >= 60)
        begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwr <= wr;
        pad <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        for (t = 0; t < 60 && prdy !== 1'b1; t++)
            @(posedge mclk);
        tmo(t);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic int lv(input int i);
        return (i % 8 == 0) ? int'(p0) : (i % 8 == 4) ? int'(p4) : i % 8;
    endfunction
    function automatic int pick(input logic [15:0] p);
        logic [15:0] e;
        int b;
        e = (fair && (p & ~served) != 16'h0) ? (p & ~served) : p;
        b = -1;
        for (int i = 0; i < 16; i++)
            if (e[i] && (b < 0 || lv(i) < lv(b)))
                b = i;
        return b;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic wt(input logic v);
        int t;
        for (t = 0; t < 60 && (gnt != 16'h0) !== v; t++)
            @(posedge mclk);
        tmo(t);
    endtask
    task automatic ld(input logic [15:0] m);
        want <= m;
        load <= 1'b1;
        @(posedge mclk);
        load <= 1'b0;
    endtask
    // runs one set of requesters through the model and the design
    task automatic run(input logic [15:0] m, input logic k, input int n);
        int b;
        pend = m;
        keep <= k;
        ld(m);
        repeat (n)
            if (pend != 16'h0)
            begin
                wt(1'b1);
                b = pick(pend);
                w = 16'h1 << b;
                chk("grant", 32'(gnt), 32'(w));
                chk("level", 32'(lines.level), 32'(lv(b)));
                chk("width", 32'(x16), 32'(size16[b]));
                chk("burst", 32'(lines.burst), 32'(burst[b]));
                served = ((pend & ~served & ~w) == 16'h0) ? 16'h0 : (served | w);
                if (!k)
                    pend = pend & ~w;
                wt(1'b0);
            end
        ld(16'h0);
        repeat (8) @(posedge mclk);
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            chk("reg", rd, rv[i]);
            chk("err", 32'(er), 32'(i == 6));
        end
        apb(1'b1, 8'h00, 32'h0);
        ld(16'h0001);
        repeat (8) @(posedge mclk);
        chk("masked", 32'(gnt), 32'h0);
        ld(16'h0000);
        apb(1'b1, 8'h00, 32'h3);
        fair = 1'b1;
        run(16'h0103, 1'b1, 6);
        apb(1'b1, 8'h00, 32'h1);
        fair = 1'b0;
        run(16'h0103, 1'b1, 3);
        for (int i = 0; i < 10; i++)
        begin
            if (i == 5)
            begin
                apb(1'b1, 8'h04, 32'hf);
                p0 = 4'hf;
                p4 = 4'h0;
            end
            seed = xs(seed);
            slow <= seed[16];
            run(seed[15:0] & 16'hfffb, 1'b0, 16);
        end
        apb(1'b1, 8'h28, 32'h10);
        run(16'h0004, 1'b0, 1);
        apb(1'b0, 8'h28, 32'h0);
        chk("count", rd, 32'he);
        give_verdict();
    end
endmodule
`default_nettype wire
